// [hw/nlr_defines.svh]
`ifndef NLR_DEFINES_SVH
`define NLR_DEFINES_SVH

// ************************************************************
// clock and cycle conversion
// ************************************************************
`define NLR_CLK_PS 25000
// least times round up, longest times round down, never below one cycle
`define NLR_CYC_UP(ns) ((((ns) * 1000 + `NLR_CLK_PS - 1) / `NLR_CLK_PS) < 1 ? 1 : \
  (((ns) * 1000 + `NLR_CLK_PS - 1) / `NLR_CLK_PS))
`define NLR_CYC_DN(ns) ((((ns) * 1000) / `NLR_CLK_PS) < 1 ? 1 : (((ns) * 1000) / `NLR_CLK_PS))

// ************************************************************
// times in ns
// ************************************************************
`define NLR_TX_ABORT_DETECT_NS 100
`define NLR_NATIVE_RESET_DETECT_NS 1000
`define NLR_REPEATER_RESET_DETECT_NS 2500
`define NLR_PORT_RESET_TX_NS 3000
`define NLR_CONFIG_IDLE_NS 1000
`define NLR_CONFIG_COMPLETE_NS 1000
`define NLR_CONFIG_QUALIFY_NS 200
`define NLR_ANALOG_PING_WIDTH_NS 100
`define NLR_ANALOG_PING_WINDOW_NS 800

// ************************************************************
// cycle counts
// ************************************************************
`define NLR_TX_ABORT_CYC `NLR_CYC_UP(`NLR_TX_ABORT_DETECT_NS)
`define NLR_NATIVE_RESET_CYC `NLR_CYC_UP(`NLR_NATIVE_RESET_DETECT_NS)
`define NLR_REPEATER_RESET_CYC `NLR_CYC_UP(`NLR_REPEATER_RESET_DETECT_NS)
`define NLR_PORT_RESET_TX_CYC `NLR_CYC_UP(`NLR_PORT_RESET_TX_NS)
`define NLR_CONFIG_IDLE_CYC `NLR_CYC_UP(`NLR_CONFIG_IDLE_NS)
`define NLR_CONFIG_COMPLETE_CYC `NLR_CYC_DN(`NLR_CONFIG_COMPLETE_NS)
`define NLR_CONFIG_QUALIFY_CYC `NLR_CYC_UP(`NLR_CONFIG_QUALIFY_NS)
`define NLR_ANALOG_PING_WIDTH_CYC `NLR_CYC_UP(`NLR_ANALOG_PING_WIDTH_NS)
`define NLR_ANALOG_PING_WINDOW_CYC `NLR_CYC_DN(`NLR_ANALOG_PING_WINDOW_NS)

// ************************************************************
// line encodings {eD+, eD-}
// ************************************************************
`define NLR_LINE_SE0 2'h0
`define NLR_LINE_SE1 2'h3
`define NLR_LINE_DP 2'h2
`define NLR_LINE_DM 2'h1

`endif

// [hw/nlr_pkg.sv]
package nlr_pkg;

  typedef enum logic [1:0] {
    NLR_SPD_LS = 2'h0,
    NLR_SPD_FS = 2'h1,
    NLR_SPD_HS = 2'h2
  } nlr_speed_t;

  typedef enum logic [2:0] {
    NLR_ST_RST_TX = 3'h0,
    NLR_ST_CFG_IDLE = 3'h1,
    NLR_ST_CFG_DRV = 3'h2,
    NLR_ST_WAIT_CFG = 3'h3,
    NLR_ST_CFG_ACK = 3'h4,
    NLR_ST_RUN = 3'h5
  } nlr_state_t;

  typedef struct packed {
    nlr_state_t st;
    logic [15:0] cnt;
    logic [15:0] pcnt;
    logic [1:0] val;
    logic [1:0] oe;
    logic tx_abort;
    logic rst_rcvd;
    logic soft_rcvd;
    logic disc;
    logic cfg_done;
    logic hs_term;
    logic ping_on;
    logic eop_short;
    logic eop_hold;
    logic aping_wait;
    logic aping_seen;
    logic aping_tx;
    logic squelch;
    logic silent;
    logic device_role;
  } nlr_regs_t;

endpackage

// [hw/nlr_line_if.sv]
`timescale 1ns/1ps
interface nlr_line_if;
  logic [1:0] raw;
  logic [1:0] line;
  modport sync (input raw, output line);
  modport user (output raw, input line);
endinterface

// [hw/nlr_sync.sv]
`timescale 1ns/1ps
// ************************************************************
// three-stage pin synchroniser, change taken when stages 2 and 3 agree
// ************************************************************
module nlr_sync (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // lines
  nlr_line_if.sync lif
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] q;
  } nlr_sync_t;

  nlr_sync_t r;
  nlr_sync_t next_r;

  always_comb begin
    next_r = r;
    next_r.s1 = lif.raw;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // filter rejects a single-cycle glitch on the pins
    if (r.s2 == r.s3) begin
      next_r.q = r.s3;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign lif.line = r.q;
endmodule

// [hw/nlr_timer.sv]
`timescale 1ns/1ps
// ************************************************************
// saturating duration counter
// ************************************************************
module nlr_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control
  input wire logic run,
  output logic [W-1:0] count
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } nlr_timer_t;

  nlr_timer_t r;
  nlr_timer_t next_r;

  always_comb begin
    next_r = r;
    if (!run) begin
      next_r.cnt = '0;
    end else if (r.cnt != {W{1'b1}}) begin
      next_r.cnt = r.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign count = r.cnt;
endmodule

// [hw/nlr_port.sv]
`timescale 1ns/1ps
`include "nlr_defines.svh"

// Function
// - downstream sends port reset after power-up or hw_reset_req, not after a received port reset
// - upstream sends port reset only on soft disconnect or on high-speed reconnect after silence
// - upstream never resets on power-up, device role
// - upstream declares reset using repeater threshold
// - abort transmission after short foreign SE1
// - native threshold: reset or soft disconnect
// - drive eD+ to enable termination, ack eD-
// - drive eD- to disable termination, ack eD+
// - downstream completes configuration soon after ack
// - upstream drives ping across EOP falling edges
// - downstream samples ping at second rising edge
// - missing digital ping means device disconnected
// - report disconnect then send port reset
// - received port reset means device disconnected
// - resume/reset end ping ends at rising edge
// - shorten high-speed start-packet EOP to 8 UI
// - keep reporting full EOP on line state
// - upstream sends analog ping after start EOP
// - upstream enables squelch right after EOP
// - missing analog ping means device disconnected
// - upstream resets on high-speed reconnect after silence
// - no disconnect check at high-speed reset/resume end
// - idle before configuration after sending reset
module nlr_port #(
  parameter bit IS_DS = 1'b1,
  parameter int TX_ABORT_CYC = `NLR_TX_ABORT_CYC,
  parameter int NATIVE_RESET_CYC = `NLR_NATIVE_RESET_CYC,
  parameter int REPEATER_RESET_CYC = `NLR_REPEATER_RESET_CYC,
  parameter int PORT_RESET_TX_CYC = `NLR_PORT_RESET_TX_CYC,
  parameter int CONFIG_IDLE_CYC = `NLR_CONFIG_IDLE_CYC,
  parameter int CONFIG_QUALIFY_CYC = `NLR_CONFIG_QUALIFY_CYC,
  parameter int APING_WIDTH_CYC = `NLR_ANALOG_PING_WIDTH_CYC,
  parameter int APING_WINDOW_CYC = `NLR_ANALOG_PING_WINDOW_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // link pins
  input wire logic ed_p_in,
  output logic ed_p_out,
  output logic ed_p_oe,
  input wire logic ed_m_in,
  output logic ed_m_out,
  output logic ed_m_oe,
  // controller requests
  input wire logic hw_reset_req,
  input wire logic soft_disconnect_req,
  input wire logic term_enable_req,
  input wire logic [1:0] speed,
  input wire logic ping_expect,
  input wire logic ping_at_resume,
  input wire logic eop_fall1,
  input wire logic eop_fall2,
  input wire logic eop_rise2,
  input wire logic sof_tx_req,
  input wire logic sof_eop_done,
  input wire logic aping_detect,
  input wire logic silent_disconnect,
  input wire logic reconnect_hs,
  // status
  output logic tx_abort,
  output logic reset_received,
  output logic soft_disconnect_received,
  output logic disconnect,
  output logic config_done,
  output logic hs_term_enable,
  output logic sof_eop_short,
  output logic linestate_eop_hold,
  output logic squelch_enable,
  output logic analog_ping_tx,
  output logic device_role
);
  // ************************************************************
  // pin synchroniser and SE1 timer
  // ************************************************************
  // sync depth plus filter plus partner release after a handshake
  localparam int SYNC_LAG = 6;

  nlr_pkg::nlr_regs_t r;
  nlr_pkg::nlr_regs_t n;
  nlr_line_if lif ();
  logic [15:0] se1_len;
  logic se1;
  logic self_se1;

  assign lif.raw = {ed_p_in, ed_m_in};
  assign se1 = lif.line == `NLR_LINE_SE1;
  // own SE1, handshake overlap and their sync echo are no partner reset; costs a few cycles of detection
  assign self_se1 = r.st == nlr_pkg::NLR_ST_RST_TX || r.st == nlr_pkg::NLR_ST_CFG_DRV ||
    r.st == nlr_pkg::NLR_ST_CFG_ACK || r.pcnt < 16'(SYNC_LAG);

  nlr_sync u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .lif(lif)
  );

  nlr_timer #(.W(16)) u_se1 (
    .clock(clock),
    .reset_n(reset_n),
    .run(se1 && !self_se1),
    .count(se1_len)
  );

  // ************************************************************
  // state
  // ************************************************************
  localparam nlr_pkg::nlr_regs_t RST = '{
    st: (IS_DS ? nlr_pkg::NLR_ST_RST_TX : nlr_pkg::NLR_ST_WAIT_CFG),
    device_role: !IS_DS,
    default: '0
  };

  logic hs;
  logic ack;
  logic smp;

  assign hs = speed == nlr_pkg::NLR_SPD_HS;
  assign ack = term_enable_req ? lif.line[0] : lif.line[1];
  assign smp = (speed == nlr_pkg::NLR_SPD_FS) ? lif.line[0] : lif.line[1];

  always_comb begin
    n = r;
    n.rst_rcvd = 1'b0;
    n.soft_rcvd = 1'b0;
    n.disc = 1'b0;
    if (r.cnt != 16'hffff) begin
      n.cnt = r.cnt + 16'h1;
    end
    if (r.pcnt != 16'hffff) begin
      n.pcnt = r.pcnt + 16'h1;
    end
    n.tx_abort = se1 && !self_se1 && (se1_len >= 16'(TX_ABORT_CYC));
    n.silent = r.silent || silent_disconnect;
    unique case (r.st)
      nlr_pkg::NLR_ST_RST_TX: begin
        n.oe = `NLR_LINE_SE1;
        n.val = `NLR_LINE_SE1;
        if (r.cnt >= 16'(PORT_RESET_TX_CYC)) begin
          n.oe = `NLR_LINE_SE0;
          n.val = `NLR_LINE_SE0;
          n.cnt = '0;
          n.pcnt = '0;
          n.st = IS_DS ? nlr_pkg::NLR_ST_CFG_IDLE : nlr_pkg::NLR_ST_WAIT_CFG;
        end
      end
      nlr_pkg::NLR_ST_CFG_IDLE: begin
        // idle restarts on any activity on the bus
        if (lif.line != `NLR_LINE_SE0) begin
          n.cnt = '0;
        end else if (r.cnt >= 16'(CONFIG_IDLE_CYC - 1)) begin
          n.st = nlr_pkg::NLR_ST_CFG_DRV;
          n.oe = term_enable_req ? `NLR_LINE_DP : `NLR_LINE_DM;
          n.val = term_enable_req ? `NLR_LINE_DP : `NLR_LINE_DM;
        end
      end
      nlr_pkg::NLR_ST_CFG_DRV: begin
        if (ack) begin
          n.pcnt = '0;
          n.oe = `NLR_LINE_SE0;
          n.val = `NLR_LINE_SE0;
          n.cfg_done = 1'b1;
          n.st = nlr_pkg::NLR_ST_RUN;
        end
      end
      nlr_pkg::NLR_ST_WAIT_CFG: begin
        // short SE1 from a partner still in power-on is simply ignored
        if (se1_len == 16'(REPEATER_RESET_CYC)) begin
          n.rst_rcvd = 1'b1;
        end
        if (lif.line != `NLR_LINE_DP && lif.line != `NLR_LINE_DM) begin
          n.cnt = '0;
        end else if (r.cnt >= 16'(CONFIG_QUALIFY_CYC - 1)) begin
          n.hs_term = lif.line[1];
          n.oe = lif.line[1] ? `NLR_LINE_DM : `NLR_LINE_DP;
          n.val = lif.line[1] ? `NLR_LINE_DM : `NLR_LINE_DP;
          n.st = nlr_pkg::NLR_ST_CFG_ACK;
        end
      end
      nlr_pkg::NLR_ST_CFG_ACK: begin
        if (!(r.hs_term ? lif.line[1] : lif.line[0])) begin
          n.oe = `NLR_LINE_SE0;
          n.val = `NLR_LINE_SE0;
          n.cfg_done = 1'b1;
          n.st = nlr_pkg::NLR_ST_RUN;
        end
      end
      nlr_pkg::NLR_ST_RUN: begin
        if (IS_DS) begin
          // digital ping checked only at low or full speed
          if (ping_expect && eop_rise2 && !hs && !smp) begin
            n.disc = 1'b1;
            n.st = nlr_pkg::NLR_ST_RST_TX;
            n.cnt = '0;
          end
          if (sof_tx_req && hs) begin
            n.eop_short = 1'b1;
            n.eop_hold = 1'b1;
          end
          if (sof_eop_done && r.eop_short) begin
            n.eop_short = 1'b0;
            n.aping_wait = 1'b1;
            n.aping_seen = 1'b0;
            n.pcnt = '0;
          end
          if (r.aping_wait) begin
            n.aping_seen = r.aping_seen || aping_detect;
            if (r.pcnt >= 16'(APING_WINDOW_CYC - 1)) begin
              n.aping_wait = 1'b0;
              n.eop_hold = 1'b0;
              if (!r.aping_seen && !aping_detect) begin
                n.disc = 1'b1;
                n.st = nlr_pkg::NLR_ST_RST_TX;
                n.cnt = '0;
              end
            end
          end
        end else begin
          if (eop_fall1 && !hs) begin
            n.ping_on = 1'b1;
            n.oe = (speed == nlr_pkg::NLR_SPD_FS) ? `NLR_LINE_DM : `NLR_LINE_DP;
            n.val = (speed == nlr_pkg::NLR_SPD_FS) ? `NLR_LINE_DM : `NLR_LINE_DP;
          end
          if (r.ping_on && (ping_at_resume ? eop_rise2 : eop_fall2)) begin
            n.ping_on = 1'b0;
            n.oe = `NLR_LINE_SE0;
            n.val = `NLR_LINE_SE0;
          end
          if (sof_eop_done && hs) begin
            n.squelch = 1'b1;
            n.aping_tx = 1'b1;
            n.pcnt = '0;
          end
          if (r.aping_tx && r.pcnt >= 16'(APING_WIDTH_CYC - 1)) begin
            n.aping_tx = 1'b0;
          end
          if (soft_disconnect_req) begin
            n.st = nlr_pkg::NLR_ST_RST_TX;
            n.cnt = '0;
          end
        end
      end
      default: begin
        n.st = RST.st;
      end
    endcase
    // ************************************************************
    // partner SE1 and local reset requests
    // ************************************************************
    if (!self_se1 && se1_len == 16'(NATIVE_RESET_CYC) && r.st != nlr_pkg::NLR_ST_WAIT_CFG) begin
      n.rst_rcvd = IS_DS;
      n.disc = IS_DS;
      n.soft_rcvd = !IS_DS;
      n.st = IS_DS ? nlr_pkg::NLR_ST_CFG_IDLE : nlr_pkg::NLR_ST_WAIT_CFG;
      n.cnt = '0;
      n.oe = `NLR_LINE_SE0;
      n.val = `NLR_LINE_SE0;
    end
    if (!IS_DS && reconnect_hs && r.silent && r.st != nlr_pkg::NLR_ST_RST_TX) begin
      n.st = nlr_pkg::NLR_ST_RST_TX;
      n.cnt = '0;
      n.silent = silent_disconnect;
    end
    if (IS_DS && hw_reset_req) begin
      n.st = nlr_pkg::NLR_ST_RST_TX;
      n.cnt = '0;
    end
    if (n.st != nlr_pkg::NLR_ST_RUN) begin
      n.cfg_done = n.st == nlr_pkg::NLR_ST_CFG_ACK ? r.cfg_done : 1'b0;
      n.ping_on = 1'b0;
      n.eop_short = 1'b0;
      n.eop_hold = 1'b0;
      n.aping_wait = 1'b0;
      n.aping_tx = 1'b0;
      n.squelch = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign ed_p_out = r.val[1];
  assign ed_p_oe = r.oe[1];
  assign ed_m_out = r.val[0];
  assign ed_m_oe = r.oe[0];
  assign tx_abort = r.tx_abort;
  assign reset_received = r.rst_rcvd;
  assign soft_disconnect_received = r.soft_rcvd;
  assign disconnect = r.disc;
  assign config_done = r.cfg_done;
  assign hs_term_enable = r.hs_term;
  assign sof_eop_short = r.eop_short;
  assign linestate_eop_hold = r.eop_hold;
  assign squelch_enable = r.squelch;
  assign analog_ping_tx = r.aping_tx;
  assign device_role = r.device_role;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  us_reset_cause_a: assert property (!IS_DS && r.st != nlr_pkg::NLR_ST_RST_TX ##1 r.st == nlr_pkg::NLR_ST_RST_TX
    |-> $past(soft_disconnect_req) || $past(reconnect_hs)) else $error("upstream reset without cause");
  us_device_role_a: assert property (!IS_DS |-> device_role) else $error("upstream not device role");
  tx_abort_a: assert property (se1 && !self_se1 && se1_len >= 16'(TX_ABORT_CYC) |=> tx_abort)
    else $error("transmit not aborted on SE1");
  ds_reset_rx_a: assert property (IS_DS && !self_se1 && se1_len == 16'(NATIVE_RESET_CYC)
    |=> disconnect && reset_received) else $error("port reset not reported");
  cfg_idle_a: assert property (r.st == nlr_pkg::NLR_ST_CFG_DRV && $past(r.st) == nlr_pkg::NLR_ST_CFG_IDLE
    |-> $past(r.cnt) >= 16'(CONFIG_IDLE_CYC - 1)) else $error("configuration without idle");
  cfg_done_a: assert property (r.st == nlr_pkg::NLR_ST_CFG_DRV && ack && !hw_reset_req && se1_len == 16'h0
    |=> config_done && !ed_p_oe && !ed_m_oe) else $error("configuration not completed");
  ping_miss_a: assert property (IS_DS && r.st == nlr_pkg::NLR_ST_RUN && ping_expect && eop_rise2 && !hs && !smp
    |=> disconnect ##1 r.st == nlr_pkg::NLR_ST_RST_TX && ed_p_oe && ed_m_oe) else $error("missed ping not reported");
  eop_hold_a: assert property (sof_eop_short |-> linestate_eop_hold) else $error("line state EOP not held");
  us_squelch_a: assert property (!IS_DS && r.st == nlr_pkg::NLR_ST_RUN && sof_eop_done && hs && se1_len == 16'h0
    && !soft_disconnect_req && !reconnect_hs |=> squelch_enable && analog_ping_tx) else $error("squelch or ping late");
endmodule

// [tb/nlr_peer.sv]
`timescale 1ns/1ps
// ************************************************************
// upstream link partner, released lines fall to pull-down
// ************************************************************
module nlr_peer (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // wire levels
  input wire logic dp,
  input wire logic dm,
  // bench controls
  input wire logic ack_en,
  input wire logic [1:0] ping_mode,
  input wire logic low_speed,
  input wire logic fall1,
  input wire logic fall2,
  input wire logic eop_done,
  input wire logic se1_go,
  input wire logic [3:0] se1_cyc,
  // drives high
  output logic drive_p,
  output logic drive_m,
  output logic aping
);
  logic [1:0] ack;
  logic [1:0] qual;
  logic [3:0] se1;
  logic ping;
  logic ping_dp;
  logic [1:0] ap;
  always @(posedge clock) begin
    if (!reset_n) begin
      ack <= 2'h0;
      qual <= 2'h0;
      se1 <= 4'h0;
      ping <= 1'b0;
      ping_dp <= 1'b0;
      ap <= 2'h0;
    end else begin
      // only on command, never from power-up
      if (se1_go) begin
        se1 <= se1_cyc;
      end else if (se1 != 4'h0) begin
        se1 <= se1 - 4'h1;
      end
      // own drives gated so we never answer ourselves
      if (ack == 2'h0) begin
        if (ack_en && (dp ^ dm) && !ping && se1 == 4'h0) begin
          qual <= qual + 2'h1;
          if (qual == 2'h3) begin
            ack <= {dm, dp};
          end
        end else begin
          qual <= 2'h0;
        end
      end else if ((ack[0] && !dp) || (ack[1] && !dm)) begin
        ack <= 2'h0;
        qual <= 2'h0;
      end
      // mode 2 pings on the wrong line
      if (fall1 && ping_mode != 2'h0) begin
        ping <= 1'b1;
        ping_dp <= low_speed ^ (ping_mode == 2'h2);
      end else if (fall2) begin
        ping <= 1'b0;
      end
      if (eop_done && ping_mode != 2'h0) begin
        ap <= 2'h2;
      end else if (ap != 2'h0) begin
        ap <= ap - 2'h1;
      end
    end
  end
  assign drive_p = ack[1] | (se1 != 4'h0) | (ping & ping_dp);
  assign drive_m = ack[0] | (se1 != 4'h0) | (ping & !ping_dp);
  assign aping = ap != 2'h0;
endmodule

// [tb/native_link_reset_config_disconnect_bench.sv]
`timescale 1ns/1ps
module native_link_reset_config_disconnect_bench;
  localparam int RST_TX = 8;
  localparam int IDLE = 4;
  localparam int NRST = 6;
  localparam int WIN = 8;
  logic soft_disconnect_req = 1'b0, ping_at_resume = 1'b0, silent_disconnect = 1'b0, reconnect_hs = 1'b0;
  int se1_run = 0;
  int se1_last = 0;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic hw_reset_req = 1'b0;
  logic term_enable_req = 1'b1;
  logic [1:0] speed = 2'h1;
  logic ping_expect = 1'b0;
  logic eop_fall1 = 1'b0;
  logic eop_fall2 = 1'b0;
  logic eop_rise2 = 1'b0;
  logic sof_tx_req = 1'b0;
  logic sof_eop_done = 1'b0;
  logic ack_en = 1'b1;
  logic [1:0] ping_mode = 2'h1;
  logic se1_go = 1'b0;
  logic [3:0] se1_cyc = 4'h0;
  logic ed_p_out, ed_p_oe, ed_m_out, ed_m_oe, tx_abort, reset_received, disconnect;
  logic config_done, sof_eop_short, linestate_eop_hold, device_role, drive_p, drive_m, aping;
  logic ed_p, ed_m;
  int miscompares = 0;
  int n_compared = 0;
  int n_disc = 0;
  int n_rst = 0;
  int n_abort = 0;
  int cycles = 0;
  integer seed;

  // pull-down wire, high wins
  assign ed_p = (ed_p_oe & ed_p_out) | drive_p;
  assign ed_m = (ed_m_oe & ed_m_out) | drive_m;
  always #12.5 clock = ~clock;

  nlr_port #(.IS_DS(1'b1), .NATIVE_RESET_CYC(NRST), .PORT_RESET_TX_CYC(RST_TX), .CONFIG_IDLE_CYC(IDLE),
    .APING_WINDOW_CYC(WIN)) i_nlr_port (
    .clock, .reset_n, .ed_p_in(ed_p), .ed_p_out, .ed_p_oe, .ed_m_in(ed_m), .ed_m_out, .ed_m_oe,
    .hw_reset_req, .soft_disconnect_req, .term_enable_req, .speed, .ping_expect,
    .ping_at_resume, .eop_fall1, .eop_fall2, .eop_rise2, .sof_tx_req, .sof_eop_done,
    .aping_detect(aping), .silent_disconnect, .reconnect_hs, .tx_abort,
    .reset_received, .soft_disconnect_received(), .disconnect, .config_done,
    .hs_term_enable(), .sof_eop_short, .linestate_eop_hold, .squelch_enable(),
    .analog_ping_tx(), .device_role);

  nlr_peer i_nlr_peer (.clock, .reset_n, .dp(ed_p), .dm(ed_m), .ack_en, .ping_mode,
    .low_speed(speed == 2'h0), .fall1(eop_fall1), .fall2(eop_fall2), .eop_done(sof_eop_done),
    .se1_go, .se1_cyc, .drive_p, .drive_m, .aping);

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (disconnect === 1'b1) n_disc++;
    if (reset_received === 1'b1) n_rst++;
    if (tx_abort === 1'b1) n_abort++;
    // length of each outgoing port reset, wherever it starts
    if (ed_p_oe && ed_m_oe && ed_p_out && ed_m_out) begin
      se1_run++;
    end else if (se1_run != 0) begin
      se1_last = se1_run;
      se1_run = 0;
    end
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // optional outgoing reset, idle, then handshake
  task automatic configure(input bit se1_first, input bit term);
    int n;
    int a;
    n = 0;
    term_enable_req = term;
    if (se1_first) begin
      while (!(ed_p_oe && ed_p_out && ed_m_oe && ed_m_out) && n < 50) begin
        step(1);
        n++;
      end
      n = 0;
      while (ed_p_oe && ed_m_oe && n < 200) begin
        step(1);
        n++;
      end
    end
    n = 0;
    while (!ed_p_oe && !ed_m_oe && n < 200) begin
      step(1);
      n++;
    end
    if (se1_first) check("port reset length", RST_TX, se1_last);
    a = n_abort;
    check("config idle", 1, n >= IDLE);
    check("config line", {term, !term, term, !term}, {ed_p_oe, ed_m_oe, ed_p_out, ed_m_out});
    n = 0;
    while (config_done !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    check("config done", 1, n < 40);
    check("config release", 0, {ed_p_oe, ed_m_oe});
    step(4);
    check("no abort in handshake", 0, n_abort - a);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    int d0;
    int r0;
    int a0;
    logic [31:0] r;
    logic exp;
    seed = 32'hc78dca6c;
    step(2);
    reset_n = 1'b1;
    check("device role", 0, device_role);
    configure(1, 1);
    // short foreign SE1 ignored, long one declared
    d0 = n_disc;
    r0 = n_rst;
    se1_cyc = 4'h3;
    pulse(se1_go);
    step(12);
    check("short se1", 0, (n_rst - r0) + (n_disc - d0));
    a0 = n_abort;
    se1_cyc = 4'hc;
    pulse(se1_go);
    step(14);
    check("tx abort", 1, n_abort > a0);
    check("reset rx", 2'h3, {n_rst > r0, n_disc > d0});
    configure(0, 1);
    // digital ping, first pass hs with no ping
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      speed = (i == 0) ? 2'h2 : 2'(r[1:0] % 3);
      ping_mode = (i == 0) ? 2'h0 : 2'(r[3:2] % 3);
      ping_expect = (i == 0) | r[4];
      // upstream-only requests, a downstream end must ignore them
      {soft_disconnect_req, ping_at_resume, silent_disconnect, reconnect_hs} = r[9:6];
      d0 = n_disc;
      pulse(eop_fall1);
      step(7);
      pulse(eop_rise2);
      step(2);
      pulse(eop_fall2);
      step(3);
      exp = ping_expect && speed != 2'h2 && ping_mode != 2'h1;
      check("digital ping", exp, n_disc > d0);
      if (exp) configure(1, r[5]);
    end
    // analog ping at high speed
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      speed = 2'h2;
      ping_mode = {1'b0, r[0] | (i == 0)};
      d0 = n_disc;
      pulse(sof_tx_req);
      check("short eop", 2'h3, {sof_eop_short, linestate_eop_hold});
      step(2);
      pulse(sof_eop_done);
      check("eop hold", 2'h1, {sof_eop_short, linestate_eop_hold});
      step(12);
      check("hold end", 0, linestate_eop_hold);
      check("analog ping", !ping_mode[0], n_disc > d0);
      if (!ping_mode[0]) configure(1, r[1]);
    end
    ping_mode = 2'h1;
    pulse(hw_reset_req);
    configure(1, 0);
    tally_and_finish;
  end
endmodule
